/* hdl/tod_core.sv */
// Decoder and execute control for a 12-bit instruction word.
// Assumes the fetch path shows the word at fetch_pc in the same cycle.
// Summary of operation
// - Byte ops: 5-bit file, d picks destination
// - Add sums W and file, sets C DC Z
// - Logic ops with file change zero only
// - Count-and-skip skips on zero, two cycles
// - Rotates go through carry, carry only
// - Bit tests skip on condition, two cycles
// - Literal logic ops change zero only
// - Return loads literal, returns, two cycles
// - Standby opcode enters sleep, updates flags
// - PC writes except branch clear bit 8
// - Port read-modify-write uses pin levels
// - Direction load to port copies W
// - Direction one turns pin driver off
// - Timer write clears assigned prescaler
`default_nettype none
module tod_core #(
  parameter int unsigned GPIO_W = 6
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Fetch path
  input  wire logic [11:0]       instr_data,
  input  wire logic              instr_valid,
  output logic      [8:0]        fetch_pc,
  // Port pins and wake pin
  input  wire logic [GPIO_W-1:0] gpio_in,
  output logic      [GPIO_W-1:0] gpio_out,
  output logic      [GPIO_W-1:0] gpio_oe,
  input  wire logic              wake_in
);
  // ==========================================================
  // Declarations
  if (GPIO_W < 1 || GPIO_W > 8) begin : g_bad_width
    $error("tod_core: GPIO_W must be 1 to 8");
  end

  tod_pkg::tod_state_t state_reg;
  tod_pkg::tod_flags_t flags_reg;
  logic [7:0]  acc_reg, timer_zero_reg, presc_reg, dir_reg;
  logic [4:0]  ctrl_reg;
  logic [8:0]  stk0_reg, stk1_reg;
  logic [GPIO_W-1:0] pin_meta, gpio_sync;
  logic        wake_meta, wake_sync;
  logic [7:0]  fval, bank_rdata, res_val, mask, rate_mask;
  logic [8:0]  add_sum, sub_sum, jump_pc;
  logic [4:0]  add_dc, sub_dc;
  logic [4:0]  fa;
  logic        exec_ok, fwr, special, tick;
  logic        to_acc, to_file, upd_z, upd_c, upd_dc, c_val, dc_val;
  logic        skip, jump, do_call, do_ret, go_sleep, clr_wdt;
  logic        dir_load, illegal;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign fa      = instr_data[4:0];
  assign exec_ok = (state_reg == tod_pkg::ST_EXEC) && instr_valid
                   && ctrl_reg[tod_pkg::CTRL_RUN_BIT];
  assign fwr     = exec_ok && to_file;
  assign special = (fa == tod_pkg::F_TIMER) || (fa == tod_pkg::F_PCL)
                   || (fa == tod_pkg::F_STATUS) || (fa == tod_pkg::F_GPIO);

  // ==========================================================
  // Pin synchronisers, two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta  <= '0;
      gpio_sync <= '0;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      pin_meta  <= gpio_in;
      gpio_sync <= pin_meta;
      wake_meta <= wake_in;
      wake_sync <= wake_meta;
    end
  end

  // ==========================================================
  // Operand source; port reads always see the pins
  tod_file_bank #(.DATA_W(tod_pkg::DATA_W), .DEPTH(tod_pkg::BANK_D))
    u_bank (
      .clk   (pclk),
      .we    (fwr && !special),
      .waddr (fa),
      .wdata (res_val),
      .raddr (fa),
      .rdata (bank_rdata)
    );

  always_comb begin
    unique case (fa)
      tod_pkg::F_TIMER:  fval = timer_zero_reg;
      tod_pkg::F_PCL:    fval = fetch_pc[7:0];
      tod_pkg::F_STATUS: fval = 8'(flags_reg);
      tod_pkg::F_GPIO:   fval = 8'(gpio_sync);
      default:           fval = bank_rdata;
    endcase
  end

  // Adder and subtractor with nibble carries
  assign add_sum = {1'b0, acc_reg} + {1'b0, fval};
  assign add_dc  = {1'b0, acc_reg[3:0]} + {1'b0, fval[3:0]};
  assign sub_sum = {1'b0, fval} + {1'b0, ~acc_reg} + 9'h001;
  assign sub_dc  = {1'b0, fval[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
  assign mask    = 8'h01 << instr_data[7:5];

  // ==========================================================
  // Instruction decode
  always_comb begin
    res_val = 8'h00;
    to_acc  = 1'b0;
    to_file = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    c_val   = 1'b0;
    dc_val  = 1'b0;
    skip    = 1'b0;
    jump    = 1'b0;
    jump_pc = 9'h000;
    do_call = 1'b0;
    do_ret  = 1'b0;
    go_sleep = 1'b0;
    clr_wdt = 1'b0;
    dir_load = 1'b0;
    illegal = 1'b0;
    // Byte ops: d low to W, d high back to file
    if (instr_data[11:10] == 2'b00 && instr_data[11:6] != 6'h00) begin
      to_acc  = !instr_data[5];
      to_file = instr_data[5];
    end
    unique casez (instr_data)
      12'b0000_0000_0000: ;
      12'b0000_0000_0010: ;
      12'b0000_0000_0011: go_sleep = 1'b1;
      12'b0000_0000_0100: clr_wdt = 1'b1;
      12'b0000_0000_0101, 12'b0000_0000_0111: ;
      12'b0000_0000_0110: dir_load = 1'b1;
      12'b0000_001?_????: begin
        res_val = acc_reg;
        to_acc  = 1'b0;
        to_file = 1'b1;
      end
      12'b0000_0100_0000: begin
        to_acc  = 1'b1;
        to_file = 1'b0;
        upd_z   = 1'b1;
      end
      12'b0000_011?_????: begin
        to_acc  = 1'b0;
        to_file = 1'b1;
        upd_z   = 1'b1;
      end
      12'b0000_10??_????: begin
        res_val = sub_sum[7:0];
        {upd_c, upd_dc, upd_z} = 3'b111;
        c_val   = sub_sum[8];
        dc_val  = sub_dc[4];
      end
      12'b0000_11??_????: {res_val, upd_z} = {fval - 8'h01, 1'b1};
      12'b0001_00??_????: {res_val, upd_z} = {acc_reg | fval, 1'b1};
      12'b0001_01??_????: {res_val, upd_z} = {acc_reg & fval, 1'b1};
      12'b0001_10??_????: {res_val, upd_z} = {acc_reg ^ fval, 1'b1};
      12'b0001_11??_????: begin
        res_val = add_sum[7:0];
        {upd_c, upd_dc, upd_z} = 3'b111;
        c_val   = add_sum[8];
        dc_val  = add_dc[4];
      end
      12'b0010_00??_????: {res_val, upd_z} = {fval, 1'b1};
      12'b0010_01??_????: {res_val, upd_z} = {~fval, 1'b1};
      12'b0010_10??_????: {res_val, upd_z} = {fval + 8'h01, 1'b1};
      12'b0010_11??_????: begin
        res_val = fval - 8'h01;
        skip    = (res_val == 8'h00);
      end
      12'b0011_00??_????: begin
        res_val = {flags_reg.c, fval[7:1]};
        {upd_c, c_val} = {1'b1, fval[0]};
      end
      12'b0011_01??_????: begin
        res_val = {fval[6:0], flags_reg.c};
        {upd_c, c_val} = {1'b1, fval[7]};
      end
      12'b0011_10??_????: res_val = {fval[3:0], fval[7:4]};
      12'b0011_11??_????: begin
        res_val = fval + 8'h01;
        skip    = (res_val == 8'h00);
      end
      12'b0100_????_????: {res_val, to_file} = {fval & ~mask, 1'b1};
      12'b0101_????_????: {res_val, to_file} = {fval | mask, 1'b1};
      12'b0110_????_????: skip = ((fval & mask) == 8'h00);
      12'b0111_????_????: skip = ((fval & mask) != 8'h00);
      12'b1000_????_????: begin
        {res_val, to_acc, do_ret, jump} = {instr_data[7:0], 3'b111};
        jump_pc = {1'b0, stk0_reg[7:0]};
      end
      12'b1001_????_????: begin
        {do_call, jump} = 2'b11;
        jump_pc = {1'b0, instr_data[7:0]};
      end
      12'b101?_????_????: {jump, jump_pc} = {1'b1, instr_data[8:0]};
      12'b1100_????_????: {res_val, to_acc} = {instr_data[7:0], 1'b1};
      12'b1101_????_????: begin
        res_val = acc_reg | instr_data[7:0];
        {to_acc, upd_z} = 2'b11;
      end
      12'b1110_????_????: begin
        res_val = acc_reg & instr_data[7:0];
        {to_acc, upd_z} = 2'b11;
      end
      12'b1111_????_????: begin
        res_val = acc_reg ^ instr_data[7:0];
        {to_acc, upd_z} = 2'b11;
      end
      default: begin
        illegal = 1'b1;
        to_acc  = 1'b0;
        to_file = 1'b0;
      end
    endcase
    // A computed write to the low PC byte is a jump
    if (to_file && fa == tod_pkg::F_PCL) begin
      jump    = 1'b1;
      jump_pc = {1'b0, res_val};
    end
  end

  // ==========================================================
  // Working register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 8'h00;
    end else if (exec_ok && to_acc) begin
      acc_reg <= res_val;
    end
  end

  // Flags; instruction flag results win over a status file write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= tod_pkg::FLAGS_RESET;
    end else if (exec_ok) begin
      if (fwr && fa == tod_pkg::F_STATUS) begin
        {flags_reg.z, flags_reg.dc, flags_reg.c} <= res_val[2:0];
      end
      if (upd_z) flags_reg.z <= (res_val == 8'h00);
      if (upd_c) flags_reg.c <= c_val;
      if (upd_dc) flags_reg.dc <= dc_val;
      if (go_sleep) {flags_reg.to_n, flags_reg.pd_n} <= 2'b10;
      if (clr_wdt) {flags_reg.to_n, flags_reg.pd_n} <= 2'b11;
    end
  end

  // ==========================================================
  // Timer and prescaler
  assign rate_mask = (8'h02 << ctrl_reg[tod_pkg::CTRL_RATE_LSB +: 3])
                     - 8'h01;
  assign tick = !ctrl_reg[tod_pkg::CTRL_PSA_BIT]
                || ((presc_reg & rate_mask) == rate_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg      <= 8'h00;
      timer_zero_reg <= tod_pkg::TIMER_RESET;
    end else begin
      presc_reg <= presc_reg + 8'h01;
      if (tick) timer_zero_reg <= timer_zero_reg + 8'h01;
      if (fwr && fa == tod_pkg::F_TIMER) begin
        timer_zero_reg <= res_val;
        if (ctrl_reg[tod_pkg::CTRL_PSA_BIT]) presc_reg <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Port latch and direction; oe kept as its own flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= '0;
      dir_reg  <= tod_pkg::DIR_RESET;
      gpio_oe  <= '0;
    end else begin
      if (fwr && fa == tod_pkg::F_GPIO) gpio_out <= res_val[GPIO_W-1:0];
      if (exec_ok && dir_load) begin
        dir_reg <= acc_reg;
        gpio_oe <= ~acc_reg[GPIO_W-1:0];
      end
    end
  end

  // ==========================================================
  // Sequencer, program counter and two-deep return stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tod_pkg::ST_EXEC;
      fetch_pc  <= 9'h000;
      stk0_reg  <= 9'h000;
      stk1_reg  <= 9'h000;
    end else begin
      unique case (state_reg)
        tod_pkg::ST_EXEC: if (exec_ok) begin
          // Dummy cycle gives skips and jumps their second cycle
          if (go_sleep) state_reg <= tod_pkg::ST_SLEEP;
          else if (jump || skip) state_reg <= tod_pkg::ST_FLUSH;
          if (jump) fetch_pc <= jump_pc;
          else if (skip) fetch_pc <= fetch_pc + 9'h002;
          else fetch_pc <= fetch_pc + 9'h001;
          if (do_call) {stk1_reg, stk0_reg} <= {stk0_reg, fetch_pc + 9'h001};
          if (do_ret) stk0_reg <= stk1_reg;
        end
        tod_pkg::ST_FLUSH: state_reg <= tod_pkg::ST_EXEC;
        tod_pkg::ST_SLEEP: if (wake_sync) state_reg <= tod_pkg::ST_EXEC;
        default: state_reg <= tod_pkg::ST_EXEC;
      endcase
    end
  end

  // ==========================================================
  // APB slave: answer in the first access cycle
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      tod_pkg::OFS_ACC:   rd_word = {24'h000000, acc_reg};
      tod_pkg::OFS_FLAGS: rd_word = {25'h0, state_reg, flags_reg};
      tod_pkg::OFS_PC:    rd_word = {23'h0, fetch_pc};
      tod_pkg::OFS_CTRL:  rd_word = {27'h0, ctrl_reg};
      tod_pkg::OFS_TIMER: rd_word = {16'h0, presc_reg, timer_zero_reg};
      tod_pkg::OFS_DIR:   rd_word = {24'h000000, dir_reg};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      if (psel && !penable) prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // Control register, written only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tod_pkg::CTRL_RESET;
    end else if (psel && penable && pready && pwrite
                 && paddr == tod_pkg::OFS_CTRL) begin
      ctrl_reg <= pwdata[tod_pkg::CTRL_W-1:0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dest_file_keep: assert property (fwr && !do_ret |=>
    acc_reg == $past(acc_reg)) else $error("W changed on file dest");
  a_add_result: assert property (exec_ok && !instr_data[5]
    && instr_data[11:6] == 6'h07
    |=> acc_reg == $past(add_sum[7:0]) && flags_reg.c == $past(add_sum[8]))
    else $error("add result or carry wrong");
  a_logic_flags: assert property (exec_ok && instr_data[11:8] == 4'h1
    && instr_data[7:6] != 2'b11 |=> $stable(flags_reg.c)
    && flags_reg.z == ($past(res_val) == 8'h00)) else $error("logic flags");
  a_skip_timing: assert property (exec_ok && skip && !jump |=>
    state_reg == tod_pkg::ST_FLUSH && fetch_pc == $past(fetch_pc) + 9'h002
    ##1 state_reg == tod_pkg::ST_EXEC) else $error("skip not two cycles");
  a_rot_carry: assert property (exec_ok && instr_data[11:6] == 6'h0D
    |=> flags_reg.c == $past(fval[7]) && $stable(flags_reg.z))
    else $error("rotate carry wrong");
  a_test_skip: assert property (exec_ok && instr_data[11:8] == 4'h7
    && (fval & mask) == 8'h00 |=> fetch_pc == $past(fetch_pc) + 9'h001)
    else $error("bit test skipped wrongly");
  a_lit_zero: assert property (exec_ok && instr_data[11:10] == 2'b11
    && instr_data[9:8] != 2'b00 |=> flags_reg.z == (acc_reg == 8'h00)
    && $stable(flags_reg.c)) else $error("literal zero flag");
  a_ret_literal: assert property (exec_ok && do_ret |=>
    acc_reg == $past(instr_data[7:0]) && state_reg == tod_pkg::ST_FLUSH)
    else $error("return literal wrong");
  a_sleep_flags: assert property (exec_ok && go_sleep |=>
    !flags_reg.pd_n && flags_reg.to_n && state_reg == tod_pkg::ST_SLEEP)
    else $error("sleep entry wrong");
  a_pc_bit8: assert property (exec_ok && jump
    && instr_data[11:9] != 3'b101 |=> !fetch_pc[8]) else $error("pc bit 8");
  a_pin_source: assert property (fwr && fa == tod_pkg::F_GPIO
    && instr_data[11:6] == 6'h08 |=> gpio_out == $past(gpio_sync))
    else $error("port rmw used latch");
  a_dir_oe: assert property (exec_ok && dir_load |=>
    dir_reg == $past(acc_reg) && gpio_oe == ~dir_reg[GPIO_W-1:0])
    else $error("direction vs enable");
  a_presc_clear: assert property (fwr && fa == tod_pkg::F_TIMER
    && ctrl_reg[tod_pkg::CTRL_PSA_BIT] |=> presc_reg == 8'h00)
    else $error("prescaler not cleared");
  a_illegal_nop: assert property (exec_ok && illegal |=>
    $stable(acc_reg) && $stable(flags_reg.z) && $stable(flags_reg.c)
    && fetch_pc == $past(fetch_pc) + 9'h001) else $error("illegal not nop");

  c_skip_taken: cover property (exec_ok && skip ##2 exec_ok);
  c_call_return: cover property (exec_ok && do_call ##[2:40] exec_ok && do_ret);
  c_sleep_wake: cover property (state_reg == tod_pkg::ST_SLEEP ##1 wake_sync);
  c_dir_load: cover property (exec_ok && dir_load);
endmodule : tod_core
`default_nettype wire

/* hdl/tod_pkg.sv */
// Shared constants and types of the twelve-bit opcode decoder core.
// Assumes a single 100 MHz clock domain and an APB register slave.
`default_nettype none
package tod_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 9;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned BANK_D  = 32;

  // ==========================================================
  // File addresses with special meaning
  localparam logic [4:0] F_TIMER  = 5'h01;
  localparam logic [4:0] F_PCL    = 5'h02;
  localparam logic [4:0] F_STATUS = 5'h03;
  localparam logic [4:0] F_GPIO   = 5'h06;
  localparam logic [2:0] DIR_SEL  = 3'h6;

  // ==========================================================
  // APB register byte offsets
  localparam logic [7:0] OFS_ACC   = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_PC    = 8'h08;
  localparam logic [7:0] OFS_CTRL  = 8'h0C;
  localparam logic [7:0] OFS_TIMER = 8'h10;
  localparam logic [7:0] OFS_DIR   = 8'h14;

  // ==========================================================
  // Control register fields and reset values
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_PSA_BIT  = 1;
  localparam int unsigned CTRL_RATE_LSB = 2;
  localparam int unsigned CTRL_W        = 5;
  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  localparam logic [7:0]  DIR_RESET     = 8'hFF;
  localparam logic [7:0]  TIMER_RESET   = 8'h00;

  // ==========================================================
  // Status flags, bit 0 carry upward
  typedef struct packed {
    logic to_n;
    logic pd_n;
    logic z;
    logic dc;
    logic c;
  } tod_flags_t;
  localparam tod_flags_t FLAGS_RESET = 5'h18;

  // Sequencer states, Gray along exec-flush and exec-sleep
  typedef enum logic [1:0] {
    ST_EXEC  = 2'h0,
    ST_FLUSH = 2'h1,
    ST_SLEEP = 2'h2
  } tod_state_t;
endpackage : tod_pkg
`default_nettype wire

/* hdl/tod_file_bank.sv */
// General purpose file register bank, asynchronous read.
// Assumes the core never writes special file addresses here.
`default_nettype none
module tod_file_bank #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned DEPTH  = 32
) (
  // Clock
  input  wire logic                     clk,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [DATA_W-1:0]        wdata,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [DATA_W-1:0]        rdata
);
  // ==========================================================
  // Storage, no reset: data contents are undefined at power-up
  logic [DATA_W-1:0] mem [DEPTH];

  if (DEPTH < 2) begin : g_bad_depth
    $error("tod_file_bank: DEPTH too small");
  end

  // Single write per cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Combinational read for one-cycle execution
  assign rdata = mem[raddr];
endmodule : tod_file_bank
`default_nettype wire

/* sim/tod_prog_mem.sv */
// Program memory model facing the fetch side of the decoder core.
// Assumes the bench loads mem directly before each run.
`default_nettype none
module tod_prog_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Fetch side
  input  wire logic        slow,
  input  wire logic [8:0]  fetch_pc,
  output logic      [11:0] instr_data,
  output logic             instr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Storage and pacing
  logic [11:0] mem [512];
  logic        gap_reg;

  // Slow mode drops valid every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 1'b0;
    end else begin
      gap_reg <= slow & ~gap_reg;
    end
  end

  // Invalid words carry inverted bits, so stale data cannot pass
  assign instr_valid = ~gap_reg;
  assign instr_data  = gap_reg ? ~mem[fetch_pc] : mem[fetch_pc];
endmodule : tod_prog_mem
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the decoder core, APB and program memory.
// Assumes tod_pkg, tod_core and tod_prog_mem are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        slow    = 1'b0;
  logic        wake_in = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [5:0]  gpio_in = 6'h2D;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] instr_data;
  logic        instr_valid;
  logic [8:0]  fetch_pc;
  logic [5:0]  gpio_out;
  logic [5:0]  gpio_oe;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          checks     = 0;

  always #5 pclk = ~pclk;

  tod_core #(.GPIO_W(6)) tod_core_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_data(instr_data), .instr_valid(instr_valid),
    .fetch_pc(fetch_pc), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .wake_in(wake_in));

  tod_prog_mem tod_prog_mem_inst (.pclk(pclk), .presetn(presetn),
    .slow(slow), .fetch_pc(fetch_pc), .instr_data(instr_data),
    .instr_valid(instr_valid));

  // ==========================================================
  // Shared tasks
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Request held until the edge that samples pready high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check("pready", 1, 0);
  endtask : apb

  // Loads a program, starts the core and waits for standby
  task automatic run(logic [11:0] p[$]);
    int n;
    foreach (tod_prog_mem_inst.mem[i]) tod_prog_mem_inst.mem[i] = 12'h000;
    foreach (p[i]) tod_prog_mem_inst.mem[i] = p[i];
    apb(1'b1, tod_pkg::OFS_CTRL, 32'h1);
    n = 0;
    do begin
      apb(1'b0, tod_pkg::OFS_FLAGS, 32'h0);
      n++;
    end while (rd[6:5] !== 2'h2 && n < 40);
    if (n >= 40) check("standby reached", 32'h1, 32'h0);
  endtask : run

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    apb(1'b1, tod_pkg::OFS_ACC, 32'h55);
    apb(1'b0, tod_pkg::OFS_ACC, 32'h0);
    check("acc", 32'h0, rd);
    apb(1'b0, tod_pkg::OFS_FLAGS, 32'h0);
    check("flags", 32'h18, rd);
    apb(1'b0, tod_pkg::OFS_DIR, 32'h0);
    check("dir", 32'hFF, rd);
    apb(1'b0, tod_pkg::OFS_CTRL, 32'h0);
    check("ctrl", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, rd);
  endtask : t_reset

  // Add, literal xor, unlisted word, then standby
  task automatic t_arith();
    run('{12'hC17, 12'h030, 12'hCC2, 12'h1D0, 12'hFD9, 12'h001, 12'h003});
    check("flags", 32'h54, rd);
    apb(1'b0, tod_pkg::OFS_ACC, 32'h0);
    check("acc", 32'h0, rd);
    apb(1'b0, tod_pkg::OFS_PC, 32'h0);
    check("pc", 32'h7, rd);
  endtask : t_arith

  // Count to zero skips a word; fetch path stalls every other cycle
  task automatic t_skip();
    slow <= 1'b1;
    run('{12'hC01, 12'h031, 12'h2F1, 12'hC55, 12'hD0A, 12'h006, 12'h003});
    check("flags", 32'h50, rd);
    apb(1'b0, tod_pkg::OFS_ACC, 32'h0);
    check("acc", 32'h0B, rd);
    apb(1'b0, tod_pkg::OFS_DIR, 32'h0);
    check("dir", 32'h0B, rd);
    check("oe", 32'h34, {26'h0, gpio_oe});
    slow <= 1'b0;
  endtask : t_skip

  // Port bit clear reads pins; call, rotate, bit test, return, wake
  task automatic t_flow();
    run('{12'hC12, 12'h026, 12'h406, 12'h90A, 12'h030, 12'h370, 12'h730,
          12'hC00, 12'h003, 12'h003, 12'h8A1});
    check("flags", 32'h51, rd);
    check("gpio_out", 32'h2C, {26'h0, gpio_out});
    apb(1'b0, tod_pkg::OFS_ACC, 32'h0);
    check("acc", 32'hA1, rd);
    apb(1'b0, tod_pkg::OFS_PC, 32'h0);
    check("pc", 32'h9, rd);
    // One-cycle wake pulse; the next word sends the core back to standby
    wake_in <= 1'b1;
    @(posedge pclk);
    wake_in <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, tod_pkg::OFS_PC, 32'h0);
    check("pc after wake", 32'hA, rd);
  endtask : t_flow

  // ==========================================================
  // Verdict and run control
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200us;
    num_errors++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    do_reset();
    t_skip();
    do_reset();
    t_flow();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
